// ### rtl/cdd_divider.sv
// Cascaded two-stage channel divider with optional duty-cycle correction,
// an optional upstream prescaler and an APB register slave.
// Assumes src_clk is sampled synchronously to pclk, below half its rate.
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module cdd_stage
    import cdd_pkg::*;
#(
    parameter int W = CDD_CNT_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [W-1:0] n,
    input wire logic [W-1:0] m,
    input wire logic corr_en,
    input wire logic in_rise,
    input wire logic in_fall,
    output cdd_edge_s out
);
    logic [W-1:0] cnt_q, cnt_d;
    logic out_q, out_d;
    logic pend_q, pend_d;
    logic rise_q, fall_q;
    // Odd ratio when n+m is odd; correction then retimes the fall by half
    wire logic half_w = corr_en & (n[0] ^ m[0]);

    always_comb begin
        cnt_d = cnt_q;
        out_d = out_q;
        pend_d = pend_q;
        if (pend_q && in_fall) begin
            out_d = 1'b0;
            pend_d = 1'b0;
        end else if (in_rise) begin
            if (out_q && !pend_q) begin
                if (cnt_q == n) begin
                    cnt_d = '0;
                    if (half_w) begin
                        pend_d = 1'b1;
                    end else begin
                        out_d = 1'b0;
                    end
                end else begin
                    cnt_d = cnt_q + W'(1);
                end
            end else if (!out_q) begin
                // Low count restarts after a late fall, so the period holds
                if (cnt_q == m) begin
                    cnt_d = '0;
                    out_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + W'(1);
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            out_q <= 1'b0;
            pend_q <= 1'b0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else if (ce) begin
            cnt_q <= cnt_d;
            out_q <= out_d;
            pend_q <= pend_d;
            rise_q <= out_d & ~out_q;
            fall_q <= out_q & ~out_d;
        end
    end

    assign out = '{lvl: out_q, rise: rise_q, fall: fall_q};

    property p_plain_high;
        @(posedge pclk) disable iff (!presetn)
        $fell(out_q) && !$past(pend_q) |-> $past(cnt_q) == $past(n) && $past(in_rise);
    endproperty
    a_plain_high: assert property (p_plain_high) else $error("stage high too short or long");

    property p_half_fall;
        @(posedge pclk) disable iff (!presetn)
        $fell(out_q) && $past(half_w) |-> $past(in_fall) && $past(pend_q);
    endproperty
    a_half_fall: assert property (p_half_fall) else $error("corrected fall not on input fall");

    property p_low_len;
        @(posedge pclk) disable iff (!presetn)
        $rose(out_q) |-> $past(cnt_q) == $past(m) && $past(in_rise);
    endproperty
    a_low_len: assert property (p_low_len) else $error("stage low count wrong");

    property p_bad_setup;
        @(posedge pclk) disable iff (!presetn)
        ce && in_rise && !out_q && !pend_q && cnt_q == m && corr_en && (m != n + W'(1))
        |=> out_q && cnt_q == '0;
    endproperty
    a_bad_setup: assert property (p_bad_setup) else $error("bad setup stopped division");

endmodule : cdd_stage

////////////////////////////////////////////////////////////////////////////
module cdd_divider
    import cdd_pkg::*;
#(
    parameter int AW = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic src_clk,
    output logic clk_out
);
    function automatic logic [2*CDD_CNT_W-1:0] pre_nm(input logic [2:0] p);
        logic [CDD_CNT_W-1:0] nn;
        nn = CDD_CNT_W'(p >> 1) - CDD_CNT_W'(1);
        return {CDD_CNT_W'(p) - nn - CDD_CNT_W'(2), nn};
    endfunction : pre_nm

    function automatic logic [CDD_RATIO_W-1:0] stage_ratio(
        input logic byp, input logic [CDD_CNT_W-1:0] n, input logic [CDD_CNT_W-1:0] m);
        return byp ? CDD_RATIO_W'(1) : CDD_RATIO_W'(n) + CDD_RATIO_W'(m) + CDD_RATIO_W'(2);
    endfunction : stage_ratio

    cdd_cfg_s cfg_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q, clk_out_q, src_q;
    logic [CDD_CNT_W-1:0] hi_cnt_q;

    ////////////////////////////////////////////////////////////////////////
    // Register decode
    wire logic setup_w = psel & ~penable;
    wire logic wr_w = psel & penable & pwrite & pready_q;
    wire logic hit_ctrl_w = (paddr == AW'(CDD_CTRL_OFS));
    wire logic hit_stat_w = (paddr == AW'(CDD_STAT_OFS));
    // Field by field, so the hole at bit 19 always reads back zero
    cdd_cfg_s wr_cfg_w;
    assign wr_cfg_w = '{pre_ratio: pwdata[CDD_PRE_POS +: 3], pad: 1'b0,
        duty_correction_disable: pwdata[CDD_CORR_DIS_POS], byp2: pwdata[CDD_BYP2_POS],
        byp1: pwdata[CDD_BYP1_POS], m2: pwdata[CDD_M2_POS +: CDD_CNT_W],
        n2: pwdata[CDD_N2_POS +: CDD_CNT_W], m1: pwdata[CDD_M1_POS +: CDD_CNT_W],
        n1: pwdata[CDD_N1_POS +: CDD_CNT_W]};
    wire logic corr_en_w = ~cfg_q.duty_correction_disable;
    wire logic pre_used_w = cfg_q.pre_ratio >= CDD_PRE_MIN;
    wire logic [CDD_RATIO_W-1:0] ratio_w = CDD_RATIO_W'(
        stage_ratio(cfg_q.byp1, cfg_q.n1, cfg_q.m1)
        * stage_ratio(cfg_q.byp2, cfg_q.n2, cfg_q.m2));
    wire logic even1_w = ~(cfg_q.n1[0] ^ cfg_q.m1[0]);
    wire logic even2_w = ~(cfg_q.n2[0] ^ cfg_q.m2[0]);
    // Only flags a setup that defeats correction; division still runs
    wire logic ok1_w = cfg_q.byp1 | (even1_w ? cfg_q.m1 == cfg_q.n1
        : cfg_q.m1 == cfg_q.n1 + CDD_CNT_W'(1));
    wire logic ok2_w = cfg_q.byp2 | (even2_w ? cfg_q.m2 == cfg_q.n2
        : cfg_q.m2 == cfg_q.n2 + CDD_CNT_W'(1));
    wire logic ok_w = ok1_w & ok2_w & ~(cfg_q.byp1 & ~cfg_q.byp2)
        & ~(~cfg_q.byp1 & ~cfg_q.byp2 & even1_w & ~even2_w);
    wire logic [31:0] stat_w = (32'(ratio_w) << CDD_RATIO_POS)
        | (32'(clk_out_q) << CDD_LVL_POS) | (32'(ok_w) << CDD_OK_POS);
    wire logic [31:0] rd_w = hit_ctrl_w ? 32'(cfg_q) : (hit_stat_w ? stat_w : 32'h0);

    ////////////////////////////////////////////////////////////////////////
    // Divider chain: prescaler, first stage, second stage
    wire logic [2*CDD_CNT_W-1:0] pnm_w = pre_nm(cfg_q.pre_ratio);
    cdd_edge_s src_e, pre_e, s1_e, s2_e, l0_e, l1_e, l2_e;
    assign src_e = '{lvl: src_clk, rise: src_clk & ~src_q, fall: ~src_clk & src_q};

    cdd_stage #(.W(CDD_CNT_W)) u_pre (.pclk(pclk), .presetn(presetn), .ce(ce),
        .n(pnm_w[CDD_CNT_W-1:0]), .m(pnm_w[2*CDD_CNT_W-1:CDD_CNT_W]), .corr_en(corr_en_w),
        .in_rise(src_e.rise), .in_fall(src_e.fall), .out(pre_e));
    assign l0_e = pre_used_w ? pre_e : src_e;
    cdd_stage #(.W(CDD_CNT_W)) u_st1 (.pclk(pclk), .presetn(presetn), .ce(ce),
        .n(cfg_q.n1), .m(cfg_q.m1), .corr_en(corr_en_w),
        .in_rise(l0_e.rise), .in_fall(l0_e.fall), .out(s1_e));
    assign l1_e = cfg_q.byp1 ? l0_e : s1_e;
    cdd_stage #(.W(CDD_CNT_W)) u_st2 (.pclk(pclk), .presetn(presetn), .ce(ce),
        .n(cfg_q.n2), .m(cfg_q.m2), .corr_en(corr_en_w),
        .in_rise(l1_e.rise), .in_fall(l1_e.fall), .out(s2_e));
    assign l2_e = cfg_q.byp2 ? l1_e : s2_e;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= cdd_cfg_s'(CDD_CTRL_RST[$bits(cdd_cfg_s)-1:0]);
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            clk_out_q <= 1'b0;
            src_q <= 1'b0;
            hi_cnt_q <= '0;
        end else if (ce) begin
            pready_q <= setup_w;
            if (setup_w) begin
                prdata_q <= rd_w;
                pslverr_q <= ~(hit_ctrl_w | (hit_stat_w & ~pwrite));
            end
            if (wr_w && hit_ctrl_w) begin
                cfg_q <= wr_cfg_w;
            end
            src_q <= src_clk;
            clk_out_q <= l2_e.lvl;
            // Helper count of input rises while the prescaler is high
            if (!pre_e.lvl) begin
                hi_cnt_q <= '0;
            end else if (src_e.rise) begin
                hi_cnt_q <= hi_cnt_q + CDD_CNT_W'(1);
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign clk_out = clk_out_q;

    property p_reset_corr;
        @(posedge pclk) $rose(presetn) |-> !cfg_q.duty_correction_disable;
    endproperty
    a_reset_corr: assert property (p_reset_corr) else $error("correction off after reset");

    property p_pre_plain;
        @(posedge pclk) disable iff (!presetn)
        $fell(pre_e.lvl) && $past(!corr_en_w && pre_used_w)
        |-> hi_cnt_q == $past(pnm_w[CDD_CNT_W-1:0]) + CDD_CNT_W'(1);
    endproperty
    a_pre_plain: assert property (p_pre_plain) else $error("prescaler high time wrong");

    property p_pre_odd_fall;
        @(posedge pclk) disable iff (!presetn)
        $fell(pre_e.lvl) && $past(corr_en_w && cfg_q.pre_ratio[0]) |-> $past(src_e.fall);
    endproperty
    a_pre_odd_fall: assert property (p_pre_odd_fall) else $error("odd prescaler fall off");

    property p_even2_fall;
        @(posedge pclk) disable iff (!presetn)
        $fell(s2_e.lvl) && $past(even2_w) |-> $past(l1_e.rise);
    endproperty
    a_even2_fall: assert property (p_even2_fall) else $error("even second stage off rise");

    property p_passthru;
        @(posedge pclk) disable iff (!presetn)
        ce && cfg_q.byp1 && cfg_q.byp2 && !pre_used_w |=> clk_out_q == $past(src_clk);
    endproperty
    a_passthru: assert property (p_passthru) else $error("bypass does not follow input");

endmodule : cdd_divider

// ### rtl/cdd_pkg.sv
// Package for the cascaded channel divider with duty-cycle correction.
// Assumes a single APB clock domain; offsets are byte addresses.
package cdd_pkg;

    localparam int CDD_CNT_W = 4;
    localparam int CDD_RATIO_W = 11;

    localparam logic [11:0] CDD_CTRL_OFS = 12'h000;
    localparam logic [11:0] CDD_STAT_OFS = 12'h004;

    // Control word fields
    localparam int CDD_N1_POS = 0;
    localparam int CDD_M1_POS = 4;
    localparam int CDD_N2_POS = 8;
    localparam int CDD_M2_POS = 12;
    localparam int CDD_BYP1_POS = 16;
    localparam int CDD_BYP2_POS = 17;
    localparam int CDD_CORR_DIS_POS = 18;
    localparam int CDD_PRE_POS = 20;

    // Status word fields
    localparam int CDD_RATIO_POS = 0;
    localparam int CDD_LVL_POS = 16;
    localparam int CDD_OK_POS = 17;

    localparam logic [31:0] CDD_CTRL_RST = 32'h0000_0000;
    localparam logic [2:0] CDD_PRE_MIN = 3'h2;

    typedef struct packed {
        logic [2:0] pre_ratio;
        // Hole at bit 19 keeps the prescaler field at its word position
        logic pad;
        logic duty_correction_disable;
        logic byp2;
        logic byp1;
        logic [CDD_CNT_W-1:0] m2;
        logic [CDD_CNT_W-1:0] n2;
        logic [CDD_CNT_W-1:0] m1;
        logic [CDD_CNT_W-1:0] n1;
    } cdd_cfg_s;

    typedef struct packed {
        logic lvl;
        logic rise;
        logic fall;
    } cdd_edge_s;

endpackage : cdd_pkg

// ### verif/cdd_load.sv
// Clock load model: measures high and low time of the divided clock.
// Assumes clk_in is a level sampled on pclk; first partial period dropped.
`timescale 1ns/1ps
module cdd_load (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_in,
    output logic valid,
    output logic [15:0] hi_cnt,
    output logic [15:0] lo_cnt
);
    logic prev_q;
    logic run_q;
    logic [15:0] hc_q;
    logic [15:0] lc_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 1'b0;
            run_q <= 1'b0;
            hc_q <= 16'h0;
            lc_q <= 16'h0;
            valid <= 1'b0;
            hi_cnt <= 16'h0;
            lo_cnt <= 16'h0;
        end else begin
            prev_q <= clk_in;
            valid <= clk_in && !prev_q && run_q;
            if (clk_in && !prev_q) begin
                hi_cnt <= hc_q;
                lo_cnt <= lc_q;
                run_q <= 1'b1;
                hc_q <= 16'h1;
                lc_q <= 16'h0;
            end else if (clk_in) begin
                hc_q <= hc_q + 16'h1;
            end else begin
                lc_q <= lc_q + 16'h1;
            end
        end
    end
endmodule : cdd_load

// ### verif/tb.sv
// Bench for the cascaded divider: APB master, source clock, clock load.
// Assumes the divider answers APB with one access cycle.
`timescale 1ns/1ps
module tb
    import cdd_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic src_clk = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic clk_out;
    logic valid;
    logic [15:0] hi_cnt;
    logic [15:0] lo_cnt;
    int fail_count = 0;
    int checks = 0;
    int sh = 2;
    int sl = 2;
    int sc = 0;
    int h;
    integer seed = 32'hD839687A;
    logic [32:0] cq[$];
    logic [64:0] rq[$];
    logic [32:0] cn;
    logic [64:0] rn;

    cdd_divider DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_clk(src_clk), .clk_out(clk_out));
    cdd_load load (.pclk(pclk), .presetn(presetn), .clk_in(clk_out),
        .valid(valid), .hi_cnt(hi_cnt), .lo_cnt(lo_cnt));

    always #5 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////
    // Source clock; levels last whole pclk cycles, so no sub-cycle X time
    always @(posedge pclk) begin
        sc <= (sc >= sh + sl - 1) ? 0 : sc + 1;
        src_clk <= (sc < sh);
    end

    task give_verdict;
        if (fail_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic e, input logic [31:0] mk, input logic [31:0] x);
        int i;
        rq.push_back({e, mk, x});
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (i >= 50) begin
            fail_count++;
            give_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wait_valid;
        int i;
        for (i = 0; i < 300 && valid !== 1'b1; i++)
            @(posedge pclk);
        if (i >= 300) begin
            fail_count++;
            give_verdict();
        end
        @(posedge pclk);
    endtask : wait_valid

    function automatic logic [31:0] cf(input int pre, off, b2, b1, m2, n2, m1, n1);
        return 32'((pre << CDD_PRE_POS) | (off << CDD_CORR_DIS_POS) | (b2 << CDD_BYP2_POS)
            | (b1 << CDD_BYP1_POS) | (m2 << CDD_M2_POS) | (n2 << CDD_N2_POS)
            | (m1 << CDD_M1_POS) | (n1 << CDD_N1_POS));
    endfunction : cf

    // Old counters run on after a write, so three periods are dropped
    task run(input logic [31:0] c, input int hh, input int ll, input logic [15:0] eh,
        input logic [15:0] el, input logic ch, input logic [10:0] r, input logic ok);
        sh = hh;
        sl = ll;
        apb(1'b1, CDD_CTRL_OFS, c, 1'b0, 32'h0, 32'h0);
        repeat (3) wait_valid();
        repeat (2) cq.push_back({ch, eh, el});
        repeat (2) wait_valid();
        apb(1'b0, CDD_STAT_OFS, 32'h0, 1'b0, c[CDD_CORR_DIS_POS] ? 32'h7FF : 32'h207FF,
            {14'h0, ok, 6'h0, r});
    endtask : run

    ////////////////////////////////////////////////////////////////////////
    always @(posedge pclk) begin
        if (valid === 1'b1 && cq.size() > 0) begin
            cn = cq.pop_front();
            check("period", 32'(hi_cnt) + 32'(lo_cnt), 32'(cn[31:16]) + 32'(cn[15:0]));
            if (cn[32])
                check("high", 32'(hi_cnt), 32'(cn[31:16]));
        end
        if (psel && penable && pready === 1'b1 && rq.size() > 0) begin
            rn = rq.pop_front();
            check("pslverr", 32'(pslverr), 32'(rn[64]));
            check("prdata", prdata & rn[63:32], rn[31:0]);
        end
    end

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CDD_CTRL_OFS, 32'h0, 1'b0, 32'hFFFFFFFF, CDD_CTRL_RST);
        apb(1'b0, CDD_STAT_OFS, 32'h0, 1'b0, 32'h207FF, 32'h20004);
        apb(1'b0, 12'h008, 32'h0, 1'b1, 32'hFFFFFFFF, 32'h0);
        apb(1'b1, CDD_STAT_OFS, 32'hFFFF, 1'b1, 32'h0, 32'h0);
        run(cf(0, 0, 0, 0, 0, 0, 0, 0), 2, 2, 8, 8, 1, 4, 1);
        h = 1 + ($unsigned($random(seed)) % 3);
        run(cf(0, 0, 1, 1, 0, 0, 0, 0), h, 4 - h, h, 4 - h, 1, 1, 1);
        run(cf(0, 1, 1, 0, 0, 0, 1, 2), 2, 2, 12, 8, 1, 5, 0);
        h = 1 + ($unsigned($random(seed)) % 3);
        run(cf(0, 0, 1, 0, 0, 0, 2, 1), h, 4 - h, 8 + h, 12 - h, 1, 5, 1);
        run(cf(0, 1, 0, 0, 2, 1, 0, 0), 2, 2, 16, 24, 1, 10, 0);
        run(cf(3, 1, 1, 1, 0, 0, 0, 0), 2, 2, 4, 8, 1, 1, 0);
        run(cf(5, 1, 1, 1, 0, 0, 0, 0), 2, 2, 8, 12, 1, 1, 0);
        run(cf(4, 1, 1, 1, 0, 0, 0, 0), 2, 2, 8, 8, 1, 1, 0);
        run(cf(3, 0, 1, 1, 0, 0, 0, 0), 2, 2, 6, 6, 1, 1, 1);
        run(cf(3, 0, 1, 1, 0, 0, 0, 0), 1, 3, 5, 7, 1, 1, 1);
        run(cf(5, 0, 1, 1, 0, 0, 0, 0), 1, 3, 9, 11, 1, 1, 1);
        run(cf(2, 0, 1, 1, 0, 0, 0, 0), 1, 3, 4, 4, 1, 1, 1);
        run(cf(3, 0, 1, 0, 0, 0, 1, 1), 1, 3, 24, 24, 1, 4, 1);
        run(cf(3, 0, 1, 0, 0, 0, 1, 0), 1, 3, 17, 19, 1, 3, 1);
        run(cf(0, 0, 1, 0, 0, 0, 0, 2), 2, 2, 0, 16, 0, 4, 0);
        apb(1'b0, CDD_CTRL_OFS, 32'h0, 1'b0, 32'hFFFFFFFF, cf(0, 0, 1, 0, 0, 0, 0, 2));
        // Enable low must hold the output level, whatever the source does
        ce <= 1'b0;
        @(posedge pclk);
        h = clk_out;
        repeat (8) begin
            @(posedge pclk);
            check("frozen", 32'(clk_out), 32'(h));
        end
        ce <= 1'b1;
        give_verdict();
    end
endmodule : tb
